// *** rtl/fsps_consts.svh ***
// named offsets, field positions, reset values and timing counts for the
// flash self-program sequencer; assumes byte addresses on a 32-bit bus.
`ifndef FSPS_CONSTS_SVH
`define FSPS_CONSTS_SVH

// register byte offsets, one aligned word each
`define FSPS_ADDR_W      8
`define FSPS_OFF_CTRL    8'h00
`define FSPS_OFF_UNLOCK  8'h04
`define FSPS_OFF_PTR     8'h08
`define FSPS_OFF_LATCH   8'h0c
`define FSPS_OFF_OP      8'h10
`define FSPS_OFF_STAT    8'h14

// memory control register fields
`define FSPS_CTL_PGM     7
`define FSPS_CTL_CFG     6
`define FSPS_CTL_ERASE   4
`define FSPS_CTL_WRITE_ERROR_FLAG   3
`define FSPS_CTL_WRITE_ENABLE_BIT    2
`define FSPS_CTL_WR      1
`define FSPS_CTL_RD      0

// table operation register fields and pointer modes
`define FSPS_OP_MODE_HI  1
`define FSPS_OP_MODE_LO  0
`define FSPS_OP_WRITE    2
`define FSPS_MODE_KEEP   2'h0
`define FSPS_MODE_POSTINC 2'h1
`define FSPS_MODE_POSTDEC 2'h2
`define FSPS_MODE_PREINC 2'h3

// status register fields
`define FSPS_ST_LW       0
`define FSPS_ST_TB       1
`define FSPS_ST_UL_HI    3
`define FSPS_ST_UL_LO    2

// unlock keys
`define FSPS_KEY_FIRST   8'h55
`define FSPS_KEY_SECOND  8'haa

// widths and sizes
`define FSPS_PTR_W       22
`define FSPS_HOLD_N      8
`define FSPS_HOLD_IDX_W  3
`define FSPS_LW_CNT_W    17

// reset values
`define FSPS_PTR_RST     22'h000000
`define FSPS_BYTE_RST    8'h00
`define FSPS_HOLD_RST    8'hff
`define FSPS_WORD_ZERO   32'h00000000

// ahb-lite encodings
`define FSPS_HTRANS_ACT  1
`define FSPS_HRESP_OKAY  1'b0

// long write time: figure in microseconds, clock in MHz
`define FSPS_LW_TIME_US  2000
`define FSPS_CLK_MHZ     40
`define FSPS_LW_CYCLES   (`FSPS_LW_TIME_US * `FSPS_CLK_MHZ)

`endif

// *** rtl/fsps_pkg.sv ***
// types shared by the flash self-program sequencer files;
// assumes fsps_consts.svh sits beside it on the include path.
`include "fsps_consts.svh"

package fsps_pkg;

	// table read engine, gray along idle-fetch-load
	typedef enum logic [1:0] {
		TB_IDLE  = 2'b00,
		TB_FETCH = 2'b01,
		TB_LOAD  = 2'b11
	} fsps_tb_state_t;

	// unlock sequence progress
	typedef enum logic [1:0] {
		UL_NONE  = 2'b00,
		UL_FIRST = 2'b01,
		UL_READY = 2'b11
	} fsps_ul_state_t;

	// long write engine
	typedef enum logic {
		LW_IDLE = 1'b0,
		LW_RUN  = 1'b1
	} fsps_lw_state_t;

	// command bundle toward the program flash array
	typedef struct packed {
		logic        erase_en;   // row erase in progress
		logic        prog_en;    // block program in progress
		logic        rd_en;      // word read request
		logic [20:0] rd_addr;    // word address of read
		logic [15:0] row_addr;   // 64-byte row number
		logic [18:0] blk_addr;   // 8-byte block number
		logic [63:0] prog_data;  // holding bytes, byte 0 lowest
	} fsps_flash_cmd_t;

endpackage : fsps_pkg

// *** rtl/fsps_prog_timer.sv ***
// internal programming timer of the flash self-program sequencer;
// assumes a start pulse only while idle, one clock, synchronous reset.
`timescale 1ns/1ps
`include "fsps_consts.svh"

module fsps_prog_timer #(
	parameter int unsigned CYCLES = `FSPS_LW_CYCLES  // length of one long write
) (
	input  wire logic clk,    // system clock
	input  wire logic reset,  // synchronous, active high
	input  wire logic start,  // one-cycle launch
	output logic      busy,   // timing in progress
	output logic      done    // one-cycle end pulse
);

	logic [`FSPS_LW_CNT_W-1:0] cnt;
	logic [`FSPS_LW_CNT_W-1:0] next_cnt;
	logic                      next_busy;
	logic                      next_done;

	// count down; a reset mid-run simply drops the operation
	always_comb begin
		next_cnt  = cnt;
		next_busy = busy;
		next_done = 1'b0;
		if (start && !busy) begin
			next_cnt  = `FSPS_LW_CNT_W'(CYCLES);
			next_busy = 1'b1;
		end else if (busy) begin
			next_cnt = cnt - `FSPS_LW_CNT_W'(1);
			if (cnt == `FSPS_LW_CNT_W'(1)) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt  <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	a_timer_load: assert property (@(posedge clk) disable iff (reset) // see [R11]
		start && !busy |=> busy && cnt == `FSPS_LW_CNT_W'(CYCLES))
		else $error("timer did not load the long write length");

	a_timer_end: assert property (@(posedge clk) disable iff (reset) // see [R17]
		$rose(done) |-> $past(cnt) == `FSPS_LW_CNT_W'(1) && !busy)
		else $error("timer ended before its count ran out");

endmodule : fsps_prog_timer

// *** rtl/fsps_top.sv ***
// flash self-program sequencer: table reads, holding registers, row erase
// and block program behind an ahb-lite slave; assumes one slave on the bus,
// a synchronous flash array answering a read one cycle after rd_en.
//
// Notes on behaviour
// [R1] a table read returns one byte only
// [R2] table read loads latch, pointer optionally steps
// [R3] pointer bit zero picks high or low byte
// [R4] erase always clears one whole 64-byte row
// [R5] erase row taken from pointer bits 21:6
// [R6] firmware sets selects, enable, erase before erase
// [R7] erase ignores the table latch contents
// [R8] firmware writes 55h, AAh, then sets write control
// [R9] long write stalls cpu, internal timer ends it
// [R10] write control set after unlock starts erase
// [R11] row erase stalls about 2 ms
// [R12] programming always covers one 8-byte block
// [R13] eight holding bytes, table writes never touch array
// [R14] firmware fills eight bytes, then launches write
// [R15] firmware loads block start, fills with auto-increment
// [R16] firmware sets selects and enable before programming
// [R17] block program stalls about 2 ms
// [R18] firmware buffers row, erases, programs eight blocks
// [R19] full row update takes roughly 18 ms
// [R20] firmware verifies with table reads afterwards
// [R21] write control refused while write enable clear
// [R22] hardware clears read and write control itself
// [R23] pointer bits 2:0 pick holding byte
// [R24] reset during long write sets error flag
// [R25] write control only right after both keys
`timescale 1ns/1ps
`include "fsps_consts.svh"

module fsps_top #(
	parameter int unsigned LW_CYCLES = `FSPS_LW_CYCLES  // cycles per long write
) (
	input  wire logic                   clk,          // 40 MHz system clock
	input  wire logic                   reset,        // synchronous, active high
	input  wire logic                   hsel,         // slave select
	input  wire logic [31:0]            haddr,        // byte address
	input  wire logic [1:0]             htrans,       // transfer type
	input  wire logic                   hwrite,       // write when high
	input  wire logic [2:0]             hsize,        // word only
	input  wire logic [31:0]            hwdata,       // write data
	input  wire logic                   hready,       // bus ready
	output logic                        hreadyout,    // slave ready
	output logic [31:0]                 hrdata,       // read data
	output logic                        hresp,        // always okay
	input  wire logic [15:0]            flash_rdata,  // array word out
	output fsps_pkg::fsps_flash_cmd_t   flash_cmd,    // array commands
	output logic                        cpu_stall     // halts instruction flow
);

	////////////////////////////////////////////////////////////////////////////
	// state
	logic                         dp_valid;
	logic                         dp_write;
	logic [`FSPS_ADDR_W-1:0]      dp_addr;
	logic                         program_memory_select;
	logic                         config_space_select;
	logic                         row_erase_sel;
	logic                         write_error_flag;
	logic                         reset_q;
	logic                         write_enable_bit;
	logic                         write_ctrl;
	logic                         read_ctrl;
	logic [`FSPS_PTR_W-1:0]       table_pointer;
	logic [7:0]                   table_latch;
	logic [7:0]                   hold [`FSPS_HOLD_N];
	logic [`FSPS_PTR_W-1:0]       tb_addr;
	fsps_pkg::fsps_tb_state_t     tb_state;
	fsps_pkg::fsps_ul_state_t     ul_state;
	fsps_pkg::fsps_lw_state_t     lw_state;

	// next values
	logic                         next_dp_valid;
	logic                         next_dp_write;
	logic [`FSPS_ADDR_W-1:0]      next_dp_addr;
	logic                         next_hreadyout;
	logic [31:0]                  next_hrdata;
	logic                         next_pgm_sel;
	logic                         next_cfg_sel;
	logic                         next_row_erase;
	logic                         next_write_error_flag;
	logic                         next_write_enable_bit;
	logic                         next_write_ctrl;
	logic                         next_read_ctrl;
	logic [`FSPS_PTR_W-1:0]       next_ptr;
	logic [7:0]                   next_latch;
	logic [7:0]                   next_hold [`FSPS_HOLD_N];
	logic [`FSPS_PTR_W-1:0]       next_tb_addr;
	fsps_pkg::fsps_tb_state_t     next_tb_state;
	fsps_pkg::fsps_ul_state_t     next_ul_state;
	fsps_pkg::fsps_lw_state_t     next_lw_state;
	fsps_pkg::fsps_flash_cmd_t    next_flash;
	logic                         next_stall;

	// decoded events
	logic                         accept;
	logic                         wr_fire;
	logic                         rd_serve;
	logic                         tb_go;
	logic                         tw_fire;
	logic [`FSPS_HOLD_IDX_W-1:0]  tw_idx;
	logic                         lw_start;
	logic                         lw_done;
	logic [`FSPS_PTR_W-1:0]       ptr_plus;
	logic [`FSPS_PTR_W-1:0]       ptr_minus;
	logic [`FSPS_PTR_W-1:0]       eff_ptr;
	logic [1:0]                   op_mode;
	logic [63:0]                  hold_flat;
	logic [31:0]                  rd_word;

	// register decode, shared by bus reads and writes
	function automatic logic is_reg(input logic [`FSPS_ADDR_W-1:0] a,
	                                input logic [`FSPS_ADDR_W-1:0] off);
		return a == off;
	endfunction : is_reg

	////////////////////////////////////////////////////////////////////////////
	// bus events; writes land in the data phase once hready is high
	assign accept   = hsel && htrans[`FSPS_HTRANS_ACT] && hready;
	assign wr_fire  = dp_valid && dp_write && hreadyout;
	assign rd_serve = dp_valid && !dp_write && !hreadyout
	                  && (tb_state == fsps_pkg::TB_IDLE);

	// pointer steps touch the low 21 bits only, bit 21 stays
	assign ptr_plus  = {table_pointer[21], table_pointer[20:0] + 21'h000001};
	assign ptr_minus = {table_pointer[21], table_pointer[20:0] - 21'h000001};
	assign op_mode   = hwdata[`FSPS_OP_MODE_HI:`FSPS_OP_MODE_LO];
	assign eff_ptr   = (op_mode == `FSPS_MODE_PREINC) ? ptr_plus : table_pointer;
	assign tb_go     = wr_fire && is_reg(dp_addr, `FSPS_OFF_OP)
	                   && (lw_state == fsps_pkg::LW_IDLE);
	assign tw_fire   = tb_go && hwdata[`FSPS_OP_WRITE];
	assign tw_idx    = eff_ptr[`FSPS_HOLD_IDX_W-1:0];  // see [R23]

	// holding bytes flattened for the program command
	for (genvar i = 0; i < `FSPS_HOLD_N; i++) begin : g_flat
		assign hold_flat[i*8 +: 8] = hold[i];
	end

	// launch only after both keys, with enable and program space chosen;
	// reads do not count as an intervening access here, see status polling
	assign lw_start = wr_fire && is_reg(dp_addr, `FSPS_OFF_CTRL)
	                  && hwdata[`FSPS_CTL_WR]
	                  && write_enable_bit                         // see [R21]
	                  && (ul_state == fsps_pkg::UL_READY)         // see [R25]
	                  && program_memory_select && !config_space_select // see [R16]
	                  && (lw_state == fsps_pkg::LW_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// read data mux; unmapped offsets and the unlock register read zero
	always_comb begin
		rd_word = `FSPS_WORD_ZERO;
		if (is_reg(dp_addr, `FSPS_OFF_CTRL)) begin
			rd_word[`FSPS_CTL_PGM]   = program_memory_select;
			rd_word[`FSPS_CTL_CFG]   = config_space_select;
			rd_word[`FSPS_CTL_ERASE] = row_erase_sel;
			rd_word[`FSPS_CTL_WRITE_ERROR_FLAG] = write_error_flag;
			rd_word[`FSPS_CTL_WRITE_ENABLE_BIT]  = write_enable_bit;
			rd_word[`FSPS_CTL_WR]    = write_ctrl;
			rd_word[`FSPS_CTL_RD]    = read_ctrl;
		end
		if (is_reg(dp_addr, `FSPS_OFF_PTR))
			rd_word[`FSPS_PTR_W-1:0] = table_pointer;
		if (is_reg(dp_addr, `FSPS_OFF_LATCH))
			rd_word[7:0] = table_latch;                     // see [R1]
		if (is_reg(dp_addr, `FSPS_OFF_STAT)) begin
			rd_word[`FSPS_ST_LW] = (lw_state == fsps_pkg::LW_RUN);
			rd_word[`FSPS_ST_TB] = (tb_state != fsps_pkg::TB_IDLE);
			rd_word[`FSPS_ST_UL_HI:`FSPS_ST_UL_LO] = ul_state;
		end
	end

	// bus slave: every read takes one wait state so it sees prior writes;
	// a table read holds hready low until the latch is loaded
	always_comb begin
		next_dp_valid  = dp_valid;
		next_dp_write  = dp_write;
		next_dp_addr   = dp_addr;
		next_hrdata    = hrdata;
		if (hready) begin
			next_dp_valid = accept;
			next_dp_write = hwrite;
			next_dp_addr  = haddr[`FSPS_ADDR_W-1:0];
		end
		if (rd_serve) begin
			next_hrdata    = rd_word;
			next_hreadyout = 1'b1;
		end else begin
			next_hreadyout = (tb_state == fsps_pkg::TB_IDLE) && !tb_go
			                 && !(accept && !hwrite);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dp_valid  <= 1'b0;
			dp_write  <= 1'b0;
			dp_addr   <= '0;
			hreadyout <= 1'b1;
			hrdata    <= `FSPS_WORD_ZERO;
			hresp     <= `FSPS_HRESP_OKAY;
		end else begin
			dp_valid  <= next_dp_valid;
			dp_write  <= next_dp_write;
			dp_addr   <= next_dp_addr;
			hreadyout <= next_hreadyout;
			hrdata    <= next_hrdata;
			hresp     <= `FSPS_HRESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// engine: unlock, control bits, table ops and long write launch
	always_comb begin
		next_pgm_sel    = program_memory_select;
		next_cfg_sel    = config_space_select;
		next_row_erase  = row_erase_sel;
		next_write_error_flag      = write_error_flag;
		next_write_enable_bit       = write_enable_bit;
		next_write_ctrl = write_ctrl;
		next_read_ctrl  = 1'b0;                             // see [R22]
		next_ptr        = table_pointer;
		next_latch      = table_latch;
		next_hold       = hold;
		next_tb_addr    = tb_addr;
		next_tb_state   = tb_state;
		next_ul_state   = ul_state;
		next_lw_state   = lw_state;
		next_flash      = flash_cmd;
		next_flash.rd_en = 1'b0;

		// any other write breaks the key sequence
		if (wr_fire)
			next_ul_state = fsps_pkg::UL_NONE;              // see [R25]
		if (wr_fire && is_reg(dp_addr, `FSPS_OFF_UNLOCK)) begin
			if (hwdata[7:0] == `FSPS_KEY_FIRST)
				next_ul_state = fsps_pkg::UL_FIRST;         // see [R8]
			else if (hwdata[7:0] == `FSPS_KEY_SECOND && ul_state == fsps_pkg::UL_FIRST)
				next_ul_state = fsps_pkg::UL_READY;
		end

		// hardware clears first, so a software write in the same cycle wins
		if (lw_done && flash_cmd.erase_en)
			next_row_erase = 1'b0;                          // see [R4]
		if (wr_fire && is_reg(dp_addr, `FSPS_OFF_CTRL)) begin
			next_pgm_sel   = hwdata[`FSPS_CTL_PGM];
			next_cfg_sel   = hwdata[`FSPS_CTL_CFG];
			next_row_erase = hwdata[`FSPS_CTL_ERASE];
			next_write_error_flag     = hwdata[`FSPS_CTL_WRITE_ERROR_FLAG];
			next_write_enable_bit      = hwdata[`FSPS_CTL_WRITE_ENABLE_BIT];
			// read control cannot be set while program space is chosen
			next_read_ctrl = hwdata[`FSPS_CTL_RD] && !program_memory_select;
		end
		// software can only set write control, hardware clears it
		if (lw_start)
			next_write_ctrl = 1'b1;                         // see [R10]
		else if (lw_done)
			next_write_ctrl = 1'b0;                         // see [R22]

		if (wr_fire && is_reg(dp_addr, `FSPS_OFF_PTR))
			next_ptr = hwdata[`FSPS_PTR_W-1:0];
		if (wr_fire && is_reg(dp_addr, `FSPS_OFF_LATCH))
			next_latch = hwdata[7:0];

		// table op: pointer step, then short write or array fetch
		if (tb_go) begin
			unique case (op_mode)
				`FSPS_MODE_KEEP:    next_ptr = table_pointer;
				`FSPS_MODE_POSTINC: next_ptr = ptr_plus;        // see [R2]
				`FSPS_MODE_POSTDEC: next_ptr = ptr_minus;
				`FSPS_MODE_PREINC:  next_ptr = ptr_plus;
			endcase
			if (tw_fire) begin
				next_hold[tw_idx] = table_latch;            // see [R13]
			end else begin
				next_tb_addr       = eff_ptr;
				next_tb_state      = fsps_pkg::TB_FETCH;
				next_flash.rd_en   = 1'b1;
				next_flash.rd_addr = eff_ptr[21:1];          // see [R3]
			end
		end
		unique case (tb_state)
			fsps_pkg::TB_IDLE:  ;
			fsps_pkg::TB_FETCH: next_tb_state = fsps_pkg::TB_LOAD;
			fsps_pkg::TB_LOAD: begin
				next_tb_state = fsps_pkg::TB_IDLE;
				next_latch = tb_addr[0] ? flash_rdata[15:8] : flash_rdata[7:0]; // see [R3]
			end
			default:            next_tb_state = fsps_pkg::TB_IDLE;
		endcase

		// erase uses the row only, never the latch; program takes the block
		if (lw_start) begin
			next_lw_state        = fsps_pkg::LW_RUN;         // see [R9]
			next_flash.erase_en  = row_erase_sel;            // see [R7]
			next_flash.prog_en   = !row_erase_sel;           // see [R12]
			next_flash.row_addr  = table_pointer[21:6];      // see [R5]
			next_flash.blk_addr  = table_pointer[21:3];      // see [R23]
			next_flash.prog_data = hold_flat;
		end else if (lw_done) begin
			next_lw_state       = fsps_pkg::LW_IDLE;
			next_flash.erase_en = 1'b0;
			next_flash.prog_en  = 1'b0;
		end
		next_stall = (next_lw_state == fsps_pkg::LW_RUN);    // see [R9]

		// a reset that cuts a long write short leaves the error flag up;
		// the engine is idle after the first reset edge, so later ones hold it
		if (reset)
			next_write_error_flag = (lw_state == fsps_pkg::LW_RUN)
			             || (reset_q && write_error_flag);  // see [R24]
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			program_memory_select <= 1'b0;
			config_space_select   <= 1'b0;
			row_erase_sel         <= 1'b0;
			write_enable_bit      <= 1'b0;
			write_ctrl            <= 1'b0;
			read_ctrl             <= 1'b0;
			table_pointer         <= `FSPS_PTR_RST;
			table_latch           <= `FSPS_BYTE_RST;
			for (int i = 0; i < `FSPS_HOLD_N; i++) begin
				hold[i] <= `FSPS_HOLD_RST;
			end
			tb_addr   <= `FSPS_PTR_RST;
			tb_state  <= fsps_pkg::TB_IDLE;
			ul_state  <= fsps_pkg::UL_NONE;
			lw_state  <= fsps_pkg::LW_IDLE;
			flash_cmd <= '0;
			cpu_stall <= 1'b0;
		end else begin
			program_memory_select <= next_pgm_sel;
			config_space_select   <= next_cfg_sel;
			row_erase_sel         <= next_row_erase;
			write_enable_bit      <= next_write_enable_bit;
			write_ctrl            <= next_write_ctrl;
			read_ctrl             <= next_read_ctrl;
			table_pointer         <= next_ptr;
			table_latch           <= next_latch;
			hold      <= next_hold;
			tb_addr   <= next_tb_addr;
			tb_state  <= next_tb_state;
			ul_state  <= next_ul_state;
			lw_state  <= next_lw_state;
			flash_cmd <= next_flash;
			cpu_stall <= next_stall;
		end
		write_error_flag <= next_write_error_flag;
		reset_q          <= reset;  // tells a held reset from its first edge
	end

	////////////////////////////////////////////////////////////////////////////
	// self-timed long write; one timer serves erase and program alike
	fsps_prog_timer #(
		.CYCLES (LW_CYCLES)  // erase plus eight programs make a row update, see [R19]
	) u_timer (
		.clk   (clk),
		.reset (reset),
		.start (lw_start),   // see [R11]
		.busy  (),
		.done  (lw_done)     // see [R17]
	);

	////////////////////////////////////////////////////////////////////////////
	a_wr_needs_write_enable_bit: assert property (@(posedge clk) disable iff (reset) // see [R21]
		$rose(write_ctrl) |-> $past(write_enable_bit))
		else $error("write control set with write enable clear");

	a_wr_after_keys: assert property (@(posedge clk) disable iff (reset) // see [R25]
		$rose(write_ctrl) |-> $past(ul_state) == fsps_pkg::UL_READY
		                      && ul_state == fsps_pkg::UL_NONE)
		else $error("long write started without both keys");

	a_erase_row_pick: assert property (@(posedge clk) disable iff (reset) // see [R5]
		$rose(flash_cmd.erase_en) |-> flash_cmd.row_addr == $past(table_pointer[21:6])
		                              && !flash_cmd.prog_en && cpu_stall)
		else $error("erase row not taken from pointer bits 21:6");

	a_prog_blk_pick: assert property (@(posedge clk) disable iff (reset) // see [R12]
		$rose(flash_cmd.prog_en) |-> flash_cmd.blk_addr == $past(table_pointer[21:3])
		                             && flash_cmd.prog_data == $past(hold_flat))
		else $error("program block or data wrong at launch");

	a_done_releases: assert property (@(posedge clk) disable iff (reset) // see [R22]
		lw_done |=> !write_ctrl && !cpu_stall && !flash_cmd.erase_en && !flash_cmd.prog_en)
		else $error("long write end did not release stall and write control");

	a_erase_clears: assert property (@(posedge clk) disable iff (reset) // see [R4]
		lw_done && flash_cmd.erase_en |=> !row_erase_sel)
		else $error("row erase select survived erase completion");

	a_read_fetch: assert property (@(posedge clk) disable iff (reset) // see [R2]
		tb_go && !tw_fire |=> flash_cmd.rd_en && !hreadyout ##1 !flash_cmd.rd_en
		                      ##1 tb_state == fsps_pkg::TB_IDLE)
		else $error("table read fetch sequence broken");

	a_latch_byte: assert property (@(posedge clk) disable iff (reset) // see [R3]
		tb_state == fsps_pkg::TB_LOAD |=> table_latch ==
			($past(tb_addr[0]) ? $past(flash_rdata[15:8]) : $past(flash_rdata[7:0])))
		else $error("table latch got the wrong byte");

	a_hold_load: assert property (@(posedge clk) disable iff (reset) // see [R13]
		tw_fire |=> hold[$past(tw_idx)] == $past(table_latch) && !flash_cmd.rd_en)
		else $error("holding byte not loaded from latch");

	a_write_error_flag_reset: assert property (@(posedge clk) // see [R24]
		reset && lw_state == fsps_pkg::LW_RUN |=> write_error_flag)
		else $error("reset during long write left error flag clear");

endmodule : fsps_top

// *** dv/fsps_flash_model.sv ***
// behavioural program flash array for the sequencer bench;
// assumes one-cycle read latency and level erase/program enables.
`timescale 1ns/1ps
module fsps_flash_model (
	input  wire logic                      clk,  // system clock
	input  wire fsps_pkg::fsps_flash_cmd_t cmd,  // array commands
	output logic [15:0]                    rdata // word out
);
	logic [15:0] mem [int]; // unwritten words read their own address
	logic        busy = 1'b0; // long write seen last cycle
	////////////////////////////////////////////////////////////////
	// idle bus shows inverted data, so a stale read cannot pass
	always @(posedge clk) begin
		if (cmd.rd_en)
			rdata <= mem.exists(cmd.rd_addr) ? mem[cmd.rd_addr] : cmd.rd_addr[15:0];
		else
			rdata <= ~rdata;
		busy <= cmd.erase_en | cmd.prog_en;
		if (cmd.erase_en && !busy)
			for (int i = 0; i < 32; i++) mem[{cmd.row_addr, 5'(i)}] = 16'hffff;
		if (cmd.prog_en && !busy)
			for (int i = 0; i < 4; i++) mem[{cmd.blk_addr, 2'(i)}] = cmd.prog_data[16*i+:16];
	end
endmodule : fsps_flash_model

// *** dv/testbench.sv ***
// self-checking bench for the flash self-program sequencer;
// assumes design files and the flash model are compiled first.
`timescale 1ns/1ps
module testbench;
	localparam int LW = 20;     // shortened long write
	logic        clk = 1'b0;    // 40 MHz
	logic        reset = 1'b1;  // sync, active high
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hready;
	logic [31:0] hrdata;
	logic        hresp;
	logic [15:0] fdata;
	logic        stall;
	logic [31:0] rd;
	fsps_pkg::fsps_flash_cmd_t cmd;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cyc = 0;
	always #12.5 clk = ~clk;
	fsps_top #(.LW_CYCLES(LW)) u_fsps_top (.clk(clk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
		.flash_rdata(fdata), .flash_cmd(cmd), .cpu_stall(stall));
	fsps_flash_model u_fsps_flash_model (.clk(clk), .cmd(cmd), .rdata(fdata));
	////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// single transfer; waits as long as the slave stretches
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task automatic tread(input logic [21:0] p, input logic [1:0] m, input logic [7:0] e);
		xfer(1'b1, 8'h08, {10'h0, p});
		xfer(1'b1, 8'h10, {30'h0, m});
		xfer(1'b0, 8'h0c, 32'h0);
		chk("latch", {56'h0, e}, {32'h0, rd});
		chk("hresp", 64'h0, {63'h0, hresp});
	endtask : tread
	task automatic lwrite(input logic [7:0] c);
		xfer(1'b1, 8'h04, 32'h55);
		xfer(1'b1, 8'h04, 32'haa);
		xfer(1'b1, 8'h00, {24'h0, c | 8'h02});
	endtask : lwrite
	task automatic stall_len(input int e);
		int n;
		n = 0;
		#1;
		while (stall === 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("stall cycles", e, n);
		@(posedge clk);
	endtask : stall_len
	// byte reads with the pointer stepping up, then down
	task automatic scen_read;
		tread(22'h002468, 2'h1, 8'h34);
		xfer(1'b0, 8'h08, 32'h0);
		chk("pointer", 32'h2469, rd);
		tread(22'h002469, 2'h2, 8'h12);
		xfer(1'b0, 8'h08, 32'h0);
		chk("pointer", 32'h2468, rd);
	endtask : scen_read
	// row erase, pointer low bits set on purpose; first step of a row update
	task automatic scen_erase;
		xfer(1'b1, 8'h08, 32'h2468);
		xfer(1'b1, 8'h00, 32'h94);
		lwrite(8'h94);
		#1;
		chk("row", 16'h0091, cmd.row_addr);
		stall_len(LW + 1);
		xfer(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h84, rd);
		tread(22'h002440, 2'h0, 8'hff);
		tread(22'h00247f, 2'h0, 8'hff);
		tread(22'h002480, 2'h0, 8'h40);
	endtask : scen_erase
	// fill holding bytes with pre-increment, then program
	task automatic scen_program;
		xfer(1'b1, 8'h08, 32'h243f);
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, 8'h0c, 32'h10 + i);
			xfer(1'b1, 8'h10, 32'h7);
		end
		lwrite(8'h84);
		#1;
		chk("data", 64'h1716151413121110, cmd.prog_data);
		chk("block", 19'h00488, cmd.blk_addr);
		stall_len(LW + 1);
		tread(22'h002443, 2'h0, 8'h13);
	endtask : scen_program
	// refused starts: no keys, broken keys, write enable clear
	task automatic scen_refuse;
		xfer(1'b1, 8'h00, 32'h86);
		stall_len(0);
		xfer(1'b1, 8'h04, 32'h55);
		xfer(1'b1, 8'h04, 32'haa);
		xfer(1'b1, 8'h08, 32'h0);
		xfer(1'b1, 8'h00, 32'h86);
		stall_len(0);
		xfer(1'b1, 8'h00, 32'h80);
		lwrite(8'h80);
		stall_len(0);
	endtask : scen_refuse
	// reset while a program runs, held for two edges
	task automatic scen_reset;
		xfer(1'b1, 8'h00, 32'h84);
		lwrite(8'h84);
		#1;
		chk("stall", 1'b1, stall);
		repeat (3) @(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		xfer(1'b0, 8'h00, 32'h0);
		chk("error flag", 32'h08, rd);
	endtask : scen_reset
	// hang guard, far above the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc > 4000) begin
			num_errors++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		scen_read();
		scen_erase();
		scen_program();
		scen_refuse();
		scen_reset();
		close_out();
	end
endmodule : testbench
